// ### rtl/supervisory_boot_sequencer.sv
// Supervisory and boot-entry sequencer: power-on reset, boot step ordering,
// bus address strapping, dead-battery path choice and thermal shutdown.
// Assumes one 125 MHz clock; all pin and analog-comparator levels are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_defs.svh"

// Notes on behaviour
// - Central overheat disables functions, halts core
// - Central shutdown ends below threshold minus hysteresis
// - Power-path overheat quickly opens power switches
// - Detector level must persist deglitch time first
// - Both thermal shutdowns interrupt the core
// - Internal reset held until regulator valid
// - Leaving reset clocks core, sends reset interrupt
// - OTP load, register reset, trims, settle, address
// - Address from fuses, debug pins, strap
// - Dead battery: system input bad, bus good
// - Sample bus-power pin only when dead battery
// - Fast domain clocks core and USB PHY
// - Slow domain clocks timers and low-power core
// - Wait supply persistence, then enable thermal protection
module supervisory_boot_sequencer (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Supply monitors (asynchronous comparator levels)
  input  wire logic               internal_regulator_out_valid,
  input  wire logic               system_supply_input_valid,
  input  wire logic               bus_supply_valid,
  // Thermal comparators (asynchronous levels)
  input  wire logic               central_above_threshold,
  input  wire logic               central_above_release,
  input  wire logic               powerpath_above_threshold,
  input  wire logic               powerpath_above_release,
  // Strap and selection pins (asynchronous levels)
  input  wire logic [1:0]         debug_control_pins,
  input  wire logic [1:0]         addr_strap_code,
  input  wire logic               bus_power_select_pin,
  // Fuse contents
  input  wire logic [`ADDR_W-1:0] otp_addr,
  input  wire logic               otp_addr_override,
  // Core handshake
  input  wire logic               otp_load_done,
  input  wire logic               core_low_power_req,
  // Reset and clock control
  output logic                    internal_reset,
  output logic                    core_reset_irq,
  output logic                    core_clk_en,
  output logic                    core_clk_sel_slow,
  output logic                    usb_phy_clk_en,
  output logic                    slow_timer_tick,
  // Boot step strobes
  output logic                    otp_load_req,
  output logic                    reg_reset_pulse,
  output logic                    trim_load_pulse,
  output logic                    boot_done,
  // Address and power path
  output logic      [`ADDR_W-1:0] bus_addr,
  output logic                    dead_battery,
  output logic                    bus_power_path_sel,
  output logic                    bus_power_path_en,
  // Thermal protection
  output logic                    thermal_protect_en,
  output logic                    core_halt,
  output logic                    functions_disable,
  output logic                    power_switch_off,
  output logic                    central_thermal_irq,
  output logic                    powerpath_thermal_irq
);

  boot_seq_pkg::boot_state_t state_r;    // Boot step
  boot_seq_pkg::boot_state_t state_nxt;

  logic [`TIMER_W-1:0] step_cnt_r;       // Settle timer
  logic [`TIMER_W-1:0] slow_cnt_r;       // Slow tick divider
  logic                reg_ok_f;         // Filtered regulator valid
  logic                vin_ok_f;         // Filtered system input valid
  logic                vbus_ok_f;        // Filtered bus supply valid
  logic                c_hot_f;          // Central above threshold, deglitched
  logic                c_rel_f;          // Central above release, deglitched
  logic                p_hot_f;          // Power path above threshold, deglitched
  logic                p_rel_f;          // Power path above release, deglitched
  logic [`PIN_N-1:0]   pins_raw;         // Plain pins before sync
  logic [`PIN_N-1:0]   pins_s;           // Plain pins after sync
  logic [`ADDR_W-1:0]  addr_calc;        // Composed address
  logic [`ADDR_W-1:0]  bus_addr_r;       // Latched address
  logic                central_sd_r;     // Central shutdown active
  logic                powerpath_sd_r;   // Power path shutdown active
  logic                thermal_en_r;     // Thermal protection enabled
  logic                dead_r;           // Dead battery detected
  logic                path_sel_r;       // Chosen bus power path
  logic                path_en_r;        // Bus power path enabled
  logic                reset_irq_r;      // Reset interrupt pulse
  logic                c_irq_r;          // Central interrupt pulse
  logic                p_irq_r;          // Power path interrupt pulse
  logic                slow_tick_r;      // Slow domain tick

  // Regulator valid gates internal reset; no persistence beyond sync
  sync_filter #(.HOLD_CYC(12'h001), .RESET_VAL(1'b0)) u_reg_ok (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (internal_regulator_out_valid),
    .level_out (reg_ok_f)
  );

  // Supply persistence filters
  sync_filter #(.HOLD_CYC(`TIMER_W'(`SUPPLY_PERSIST_CYC)), .RESET_VAL(1'b0)) u_vin_ok (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (system_supply_input_valid),
    .level_out (vin_ok_f)
  );
  sync_filter #(.HOLD_CYC(`TIMER_W'(`SUPPLY_PERSIST_CYC)), .RESET_VAL(1'b0)) u_vbus_ok (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (bus_supply_valid),
    .level_out (vbus_ok_f)
  );

  // Thermal deglitch filters, one per comparator
  sync_filter #(.HOLD_CYC(`TIMER_W'(`THERMAL_DEGLITCH_CYC)), .RESET_VAL(1'b0)) u_c_hot (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (central_above_threshold),
    .level_out (c_hot_f)
  );
  sync_filter #(.HOLD_CYC(`TIMER_W'(`THERMAL_DEGLITCH_CYC)), .RESET_VAL(1'b0)) u_c_rel (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (central_above_release),
    .level_out (c_rel_f)
  );
  sync_filter #(.HOLD_CYC(`TIMER_W'(`THERMAL_DEGLITCH_CYC)), .RESET_VAL(1'b0)) u_p_hot (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (powerpath_above_threshold),
    .level_out (p_hot_f)
  );
  sync_filter #(.HOLD_CYC(`TIMER_W'(`THERMAL_DEGLITCH_CYC)), .RESET_VAL(1'b0)) u_p_rel (
    .clk       (clk),
    .reset     (reset),
    .raw_in    (powerpath_above_release),
    .level_out (p_rel_f)
  );

  // Plain pins: two-flop sync plus a one-cycle filter stage
  assign pins_raw = {bus_power_select_pin, addr_strap_code, debug_control_pins};
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_N; gi = gi + 1) begin : g_pin
      sync_filter #(.HOLD_CYC(12'h001), .RESET_VAL(1'b0)) u_pin (
        .clk       (clk),
        .reset     (reset),
        .raw_in    (pins_raw[gi]),
        .level_out (pins_s[gi])
      );
    end
  endgenerate

  // Address from fuse bits, debug pins and strap
  bus_address_calc u_addr (
    .otp_addr           (otp_addr),
    .otp_addr_override  (otp_addr_override),
    .debug_control_pins (pins_s[`PIN_DBG1:`PIN_DBG0]),
    .strap_code         (pins_s[`PIN_STRAP1:`PIN_STRAP0]),
    .bus_addr           (addr_calc)
  );

  // Step decodes
  wire in_por     = (state_r == boot_seq_pkg::ST_POR_HOLD);
  wire settle_end = (step_cnt_r == `TIMER_W'(`TRIM_SETTLE_CYC - 1));
  wire dead_now   = !vin_ok_f && vbus_ok_f;
  wire at_db      = (state_r == boot_seq_pkg::ST_DB_CHECK);
  wire at_addr    = (state_r == boot_seq_pkg::ST_ADDR_CFG);
  wire running    = (state_r == boot_seq_pkg::ST_RUN);

  // Thermal trip and release conditions
  wire c_trip     = thermal_en_r && c_hot_f && !central_sd_r;
  wire c_release  = central_sd_r && !c_rel_f;
  wire p_trip     = thermal_en_r && p_hot_f && !powerpath_sd_r;
  wire p_release  = powerpath_sd_r && !p_rel_f;
  wire slow_wrap  = (slow_cnt_r == `TIMER_W'(`SLOW_TICK_CYC - 1));

  // Boot step order; any loss of regulator valid restarts at reset hold
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      boot_seq_pkg::ST_POR_HOLD:    state_nxt = boot_seq_pkg::ST_SUPPLY_WAIT;
      boot_seq_pkg::ST_SUPPLY_WAIT: begin
        // Either supply stable lets boot go on
        if (vin_ok_f || vbus_ok_f) begin
          state_nxt = boot_seq_pkg::ST_OTP_LOAD;
        end
      end
      boot_seq_pkg::ST_OTP_LOAD: begin
        // Core acknowledges the fuse image
        if (otp_load_done) begin
          state_nxt = boot_seq_pkg::ST_REG_RESET;
        end
      end
      boot_seq_pkg::ST_REG_RESET:   state_nxt = boot_seq_pkg::ST_TRIM_LOAD;
      boot_seq_pkg::ST_TRIM_LOAD:   state_nxt = boot_seq_pkg::ST_TRIM_SETTLE;
      boot_seq_pkg::ST_TRIM_SETTLE: begin
        // Trims need time before address pins are trusted
        if (settle_end) begin
          state_nxt = boot_seq_pkg::ST_ADDR_CFG;
        end
      end
      boot_seq_pkg::ST_ADDR_CFG:    state_nxt = boot_seq_pkg::ST_DB_CHECK;
      boot_seq_pkg::ST_DB_CHECK:    state_nxt = boot_seq_pkg::ST_RUN;
      boot_seq_pkg::ST_RUN:         state_nxt = boot_seq_pkg::ST_RUN;
    endcase
    if (!reg_ok_f) begin
      state_nxt = boot_seq_pkg::ST_POR_HOLD;
    end
  end

  // State and settle timer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r    <= boot_seq_pkg::ST_POR_HOLD;
      step_cnt_r <= 12'h000;
    end else begin
      state_r    <= state_nxt;
      step_cnt_r <= (state_r == boot_seq_pkg::ST_TRIM_SETTLE) ? step_cnt_r + 12'h001 : 12'h000;
    end
  end

  // Reset interrupt fires once as the hold ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_irq_r <= 1'b0;
    end else begin
      reset_irq_r <= in_por && reg_ok_f;
    end
  end

  // Address latched once, so later pin reuse cannot move it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_addr_r <= `ADDR_RESET;
    end else if (at_addr) begin
      bus_addr_r <= addr_calc;
    end
  end

  // Dead-battery decision and power path choice
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dead_r     <= 1'b0;
      path_sel_r <= 1'b0;
      path_en_r  <= 1'b0;
    end else if (in_por) begin
      dead_r     <= 1'b0;
      path_sel_r <= 1'b0;
      path_en_r  <= 1'b0;
    end else if (at_db) begin
      dead_r     <= dead_now;
      path_sel_r <= dead_now ? pins_s[`PIN_BUSPWR] : 1'b0;
      path_en_r  <= dead_now;
    end
  end

  // Thermal monitoring switches on only after supplies settled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thermal_en_r <= 1'b0;
    end else begin
      thermal_en_r <= !in_por && (thermal_en_r || state_r == boot_seq_pkg::ST_OTP_LOAD);
    end
  end

  // Central shutdown: trip above threshold, hold until below release level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      central_sd_r <= 1'b0;
      c_irq_r      <= 1'b0;
    end else begin
      central_sd_r <= c_trip || (central_sd_r && !c_release);
      c_irq_r      <= c_trip;
    end
  end

  // Power path shutdown runs independently of the central one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      powerpath_sd_r <= 1'b0;
      p_irq_r        <= 1'b0;
    end else begin
      powerpath_sd_r <= p_trip || (powerpath_sd_r && !p_release);
      p_irq_r        <= p_trip;
    end
  end

  // Slow timer tick, free running out of reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slow_cnt_r  <= 12'h000;
      slow_tick_r <= 1'b0;
    end else begin
      slow_cnt_r  <= slow_wrap ? 12'h000 : slow_cnt_r + 12'h001;
      slow_tick_r <= slow_wrap;
    end
  end

  // Reset and clock controls
  assign internal_reset        = in_por;
  assign core_reset_irq        = reset_irq_r;
  assign core_clk_en           = !in_por && !central_sd_r;
  assign core_clk_sel_slow     = running && core_low_power_req;
  assign usb_phy_clk_en        = core_clk_en && !core_clk_sel_slow;
  assign slow_timer_tick       = slow_tick_r;

  // Boot strobes
  assign otp_load_req          = (state_r == boot_seq_pkg::ST_OTP_LOAD);
  assign reg_reset_pulse       = (state_r == boot_seq_pkg::ST_REG_RESET);
  assign trim_load_pulse       = (state_r == boot_seq_pkg::ST_TRIM_LOAD);
  assign boot_done             = running;

  // Address and power path
  assign bus_addr              = bus_addr_r;
  assign dead_battery          = dead_r;
  assign bus_power_path_sel    = path_sel_r;
  assign bus_power_path_en     = path_en_r && !powerpath_sd_r && !central_sd_r;

  // Thermal outputs
  assign thermal_protect_en    = thermal_en_r;
  assign core_halt             = central_sd_r;
  assign functions_disable     = central_sd_r;
  assign power_switch_off      = powerpath_sd_r || central_sd_r;
  assign central_thermal_irq   = c_irq_r;
  assign powerpath_thermal_irq = p_irq_r;

endmodule

`default_nettype wire

// ### inc/boot_seq_defs.svh
// Timing counts, field positions and reset values for the supervisory boot sequencer.
// Assumes a 125 MHz system clock; all counts are derived from times given in ns.
`ifndef BOOT_SEQ_DEFS_SVH
`define BOOT_SEQ_DEFS_SVH

// Clock period in ns
`define CLK_PERIOD_NS            8
// Least time in ns to cycles, rounded up, at least one cycle
`define NS_TO_CYC(ns)            ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                                  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// Thermal deglitch time in ns
`define THERMAL_DEGLITCH_TIME_NS 10000
`define THERMAL_DEGLITCH_CYC     `NS_TO_CYC(`THERMAL_DEGLITCH_TIME_NS)
// Trim settle time in ns
`define TRIM_SETTLE_TIME_NS      1000
`define TRIM_SETTLE_CYC          `NS_TO_CYC(`TRIM_SETTLE_TIME_NS)
// Supply persistence time in ns
`define SUPPLY_PERSIST_TIME_NS   20000
`define SUPPLY_PERSIST_CYC       `NS_TO_CYC(`SUPPLY_PERSIST_TIME_NS)
// Slow timer domain period in ns (100 kHz)
`define SLOW_TICK_PERIOD_NS      10000
`define SLOW_TICK_CYC            `NS_TO_CYC(`SLOW_TICK_PERIOD_NS)

// Width of all timing counters
`define TIMER_W                  12

// Bus address field layout
`define ADDR_W                   7
`define ADDR_OTP_HI              6
`define ADDR_OTP_LO              4
`define ADDR_DBG_HI              3
`define ADDR_DBG_LO              2
`define ADDR_STRAP_HI            1
`define ADDR_STRAP_LO            0
// Address register reset value
`define ADDR_RESET               7'h00

// Pin vector layout for plain synchronised pins
`define PIN_DBG0                 0
`define PIN_DBG1                 1
`define PIN_STRAP0               2
`define PIN_STRAP1               3
`define PIN_BUSPWR               4
`define PIN_N                    5

`endif

// ### inc/boot_seq_pkg.sv
// Types shared by the supervisory boot sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_seq_pkg;

  // Boot sequence states
  typedef enum logic [3:0] {
    ST_POR_HOLD,
    ST_SUPPLY_WAIT,
    ST_OTP_LOAD,
    ST_REG_RESET,
    ST_TRIM_LOAD,
    ST_TRIM_SETTLE,
    ST_ADDR_CFG,
    ST_DB_CHECK,
    ST_RUN
  } boot_state_t;

endpackage

// ### rtl/sync_filter.sv
// Two-flop synchroniser followed by a stability filter.
// Assumes the input is asynchronous to clk; output changes only after the
// synchronised level has held for HOLD_CYC consecutive cycles.
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_defs.svh"

module sync_filter #(
  parameter logic [`TIMER_W-1:0] HOLD_CYC  = 12'h001,
  parameter logic                RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Raw level and filtered level
  input  wire logic raw_in,
  output logic      level_out
);

  logic                meta_r;   // First stage, read only by sync_r
  logic                sync_r;   // Second stage
  logic [`TIMER_W-1:0] cnt_r;    // Cycles the new level has held
  logic                level_r;  // Filtered level

  wire                 differs   = (sync_r != level_r);
  wire                 hold_done = differs && (cnt_r == HOLD_CYC - 12'h001);
  wire [`TIMER_W-1:0]  cnt_nxt   = (differs && !hold_done) ? cnt_r + 12'h001 : 12'h000;

  // Synchroniser stages
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // Short excursions restart the count and are dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r   <= 12'h000;
      level_r <= RESET_VAL;
    end else begin
      cnt_r   <= cnt_nxt;
      level_r <= hold_done ? sync_r : level_r;
    end
  end

  assign level_out = level_r;

endmodule

`default_nettype wire

// ### rtl/bus_address_calc.sv
// Composes the two-wire bus address from fuse bits, debug pins and strap code.
// Assumes all inputs are already synchronised to the caller's clock.
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_defs.svh"

module bus_address_calc (
  // Address sources
  input  wire logic [`ADDR_W-1:0] otp_addr,
  input  wire logic               otp_addr_override,
  input  wire logic [1:0]         debug_control_pins,
  input  wire logic [1:0]         strap_code,
  // Composed address
  output logic      [`ADDR_W-1:0] bus_addr
);

  // Pin-derived address keeps the fuse high bits
  wire [`ADDR_W-1:0] pin_addr = {otp_addr[`ADDR_OTP_HI:`ADDR_OTP_LO], debug_control_pins, strap_code};

  // Full fuse override lets one part ignore the board straps
  assign bus_addr = otp_addr_override ? otp_addr : pin_addr;

endmodule

`default_nettype wire

// ### testbench/boot_core_model.sv
// Behavioural core that answers the fuse load request during boot.
// Assumes it shares clk and reset with the sequencer.
`timescale 1ns/1ns
`default_nettype none

module boot_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Fuse load handshake
  input  wire logic otp_load_req,
  input  wire logic slow,
  output logic      otp_load_done
);
  logic [4:0] wait_r; // Cycles spent on the fetch

  // Fetch lasts 1 or 20 cycles; done is a one-cycle answer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_r        <= 5'h00;
      otp_load_done <= 1'b0;
    end else if (otp_load_req && !otp_load_done) begin
      wait_r        <= wait_r + 5'h01;
      otp_load_done <= (wait_r >= (slow ? 5'h13 : 5'h00));
    end else begin
      // Request gone or answered: line drops back to idle
      wait_r        <= 5'h00;
      otp_load_done <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ### testbench/supervisory_boot_sequencer_props.sv
// Concurrent checks on the sequencer's ports.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module supervisory_boot_sequencer_props (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Boot handshake
  input  wire logic otp_load_req,
  input  wire logic otp_load_done,
  input  wire logic internal_reset,
  input  wire logic core_reset_irq,
  input  wire logic reg_reset_pulse,
  input  wire logic trim_load_pulse,
  input  wire logic boot_done,
  // Power path and protection
  input  wire logic core_clk_en,
  input  wire logic dead_battery,
  input  wire logic bus_power_path_en,
  input  wire logic thermal_protect_en,
  input  wire logic core_halt,
  input  wire logic functions_disable,
  input  wire logic power_switch_off,
  input  wire logic central_thermal_irq,
  input  wire logic powerpath_thermal_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_irq_release: assert property (core_reset_irq |-> !internal_reset && $past(internal_reset))
    else $error("reset interrupt not at reset release");
  a_otp_req_holds: assert property (otp_load_req && !otp_load_done |=> otp_load_req || internal_reset)
    else $error("fuse request dropped early");
  a_boot_step_order: assert property (otp_load_req && otp_load_done |=> reg_reset_pulse ##1 trim_load_pulse)
    else $error("boot steps out of order");
  a_trim_settle_time: assert property (trim_load_pulse |-> ##127 (!boot_done || internal_reset)
    ##1 (boot_done || internal_reset))
    else $error("trim settle length wrong");
  a_halt_disables_all: assert property (core_halt |-> functions_disable && power_switch_off
    && !core_clk_en && !bus_power_path_en)
    else $error("central shutdown incomplete");
  a_central_irq_trip: assert property (central_thermal_irq |-> core_halt && !$past(core_halt))
    else $error("central interrupt without new trip");
  a_central_irq_pulse: assert property (central_thermal_irq |=> !central_thermal_irq)
    else $error("central interrupt longer than one cycle");
  a_powerpath_irq_off: assert property (powerpath_thermal_irq |-> power_switch_off && !bus_power_path_en)
    else $error("power path interrupt without switch off");
  a_path_needs_dead: assert property (bus_power_path_en |-> dead_battery)
    else $error("bus power path without dead battery");
  a_protect_on_load: assert property ($rose(otp_load_req) |=> thermal_protect_en)
    else $error("thermal protection not enabled at fuse load");
endmodule

bind supervisory_boot_sequencer supervisory_boot_sequencer_props props_u (.clk, .reset, .otp_load_req,
  .otp_load_done, .internal_reset, .core_reset_irq, .reg_reset_pulse, .trim_load_pulse, .boot_done,
  .core_clk_en, .dead_battery, .bus_power_path_en, .thermal_protect_en, .core_halt, .functions_disable,
  .power_switch_off, .central_thermal_irq, .powerpath_thermal_irq);

`default_nettype wire

// ### testbench/supervisory_boot_sequencer_test.sv
// Self-checking bench: boot cases, supply wait, thermal trips, clock modes.
// Assumes the core model answers fuse loads; comparator levels come from here.
`timescale 1ns/1ns
`default_nettype none

module supervisory_boot_sequencer_test;
  logic clk, reset, reg_ok, sys_ok, bus_ok, c_hi, c_rel, p_hi, p_rel, sel_pin, ovr, slw, lp;
  logic [1:0] dbg, strap;
  logic [6:0] otp = 7'h5A;
  logic otp_load_done, internal_reset, core_reset_irq, core_clk_en, core_clk_sel_slow, usb_phy_clk_en;
  logic slow_timer_tick, otp_load_req, reg_reset_pulse, trim_load_pulse, boot_done, dead_battery;
  logic bus_power_path_sel, bus_power_path_en, thermal_protect_en, core_halt, functions_disable;
  logic power_switch_off, central_thermal_irq, powerpath_thermal_irq;
  logic [6:0] bus_addr;
  int failures = 0, compares = 0, rst_n = 0, c_n = 0, p_n = 0, tick_n = 0;

  supervisory_boot_sequencer dut_u (.clk, .reset, .internal_regulator_out_valid(reg_ok),
    .system_supply_input_valid(sys_ok), .bus_supply_valid(bus_ok), .central_above_threshold(c_hi),
    .central_above_release(c_rel), .powerpath_above_threshold(p_hi), .powerpath_above_release(p_rel),
    .debug_control_pins(dbg), .addr_strap_code(strap), .bus_power_select_pin(sel_pin), .otp_addr(otp),
    .otp_addr_override(ovr), .otp_load_done, .core_low_power_req(lp), .internal_reset, .core_reset_irq,
    .core_clk_en, .core_clk_sel_slow, .usb_phy_clk_en, .slow_timer_tick, .otp_load_req, .reg_reset_pulse,
    .trim_load_pulse, .boot_done, .bus_addr, .dead_battery, .bus_power_path_sel, .bus_power_path_en,
    .thermal_protect_en, .core_halt, .functions_disable, .power_switch_off, .central_thermal_irq,
    .powerpath_thermal_irq);
  boot_core_model core_u (.clk, .reset, .otp_load_req, .slow(slw), .otp_load_done);

  // Clock at 125 MHz
  always #4 clk = ~clk;
  // Event tallies, cleared by the scenarios
  always @(posedge clk) begin
    rst_n += core_reset_irq;
    c_n += central_thermal_irq;
    p_n += powerpath_thermal_irq;
    tick_n += slow_timer_tick;
  end

  task automatic stop_test;
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Bounded wait for a level; running out ends the run
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk);
    if (s !== v) begin
      failures++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  endtask

  // No valid supply: boot must not pass the persistence wait, and heat is ignored before protection
  task automatic t_hold;
    {c_hi, c_rel, p_hi, p_rel} <= 4'hF;
    repeat (3000) @(posedge clk);
    #1 chk(otp_load_req === 1'b0 && thermal_protect_en === 1'b0, "left supply wait");
    chk(internal_reset === 1'b0 && rst_n == 1, "reset interrupt");
    chk(core_halt === 1'b0 && power_switch_off === 1'b0 && c_n + p_n == 0, "trip before protection");
    @(posedge clk) {c_hi, c_rel, p_hi, p_rel} <= 4'h0;
  endtask
  // Regulator loss, then a full boot with the given pins and supplies
  task automatic t_boot(input logic vin, vbus, pin, ov, sl, input logic [3:0] straps);
    logic dead;
    dead = !vin && vbus;
    @(posedge clk);
    reg_ok <= 1'b0;
    {sys_ok, bus_ok, sel_pin, ovr, slw, dbg, strap} <= {vin, vbus, pin, ov, sl, straps};
    // Supply filters must settle so the dead-battery step sees the new levels
    repeat (2600) @(posedge clk);
    #1 chk(internal_reset === 1'b1 && boot_done === 1'b0, "no reset hold");
    rst_n = 0;
    @(posedge clk) reg_ok <= 1'b1;
    wait_for(boot_done, 1'b1, 4000);
    #1 chk(rst_n == 1 && core_clk_en === 1'b1 && usb_phy_clk_en === 1'b1, "boot entry");
    chk(thermal_protect_en === 1'b1, "protection off");
    chk(bus_addr === (ov ? otp : {otp[6:4], straps}), "bus address");
    chk(dead_battery === dead && bus_power_path_en === dead, "dead battery");
    chk(bus_power_path_sel === (dead & pin), "path select");
  endtask
  // Central trip: glitch, deglitch time, hysteresis, release
  task automatic t_central;
    c_n = 0;
    @(posedge clk) {c_hi, c_rel} <= 2'h3;
    repeat (1000) @(posedge clk);
    {c_hi, c_rel} <= 2'h0;
    repeat (1400) @(posedge clk);
    #1 chk(core_halt === 1'b0 && c_n == 0, "glitch tripped");
    @(posedge clk) {c_hi, c_rel} <= 2'h3;
    repeat (1200) @(posedge clk);
    #1 chk(core_halt === 1'b0, "trip too early");
    wait_for(core_halt, 1'b1, 100);
    #1 chk(functions_disable === 1'b1 && core_clk_en === 1'b0 && power_switch_off === 1'b1, "halt");
    @(posedge clk) c_hi <= 1'b0;
    repeat (2000) @(posedge clk);
    #1 chk(core_halt === 1'b1 && c_n == 1, "released inside hysteresis");
    @(posedge clk) c_rel <= 1'b0;
    wait_for(core_halt, 1'b0, 1300);
    #1 chk(core_clk_en === 1'b1 && c_n == 1, "no resume");
  endtask
  // Power-path trip leaves the core running
  task automatic t_power;
    p_n = 0;
    @(posedge clk) {p_hi, p_rel} <= 2'h3;
    repeat (1200) @(posedge clk);
    #1 chk(power_switch_off === 1'b0, "path trip too early");
    wait_for(power_switch_off, 1'b1, 100);
    repeat (2) @(posedge clk);
    #1 chk(core_halt === 1'b0 && bus_power_path_en === 1'b0 && p_n == 1, "path trip");
    @(posedge clk) {p_hi, p_rel} <= 2'h0;
    wait_for(power_switch_off, 1'b0, 1300);
    #1 chk(bus_power_path_en === 1'b1, "path not restored");
  endtask
  // Low-power clock choice and slow tick rate
  task automatic t_clock;
    @(posedge clk) lp <= 1'b1;
    @(posedge clk);
    #1 tick_n = 0;
    chk(core_clk_sel_slow === 1'b1, "slow clock not chosen");
    repeat (2500) @(posedge clk);
    #1 chk(tick_n == 2, "slow tick rate");
    @(posedge clk) lp <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(core_clk_sel_slow === 1'b0 && usb_phy_clk_en === 1'b1, "fast clock");
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {reg_ok, sys_ok, bus_ok, c_hi, c_rel, p_hi, p_rel} = 7'h40;
    {sel_pin, ovr, slw, lp, dbg, strap} = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_hold();
    t_boot(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h6);
    t_boot(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h9);
    t_boot(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hF);
    t_boot(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h3);
    t_boot(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hC);
    t_central();
    t_power();
    t_clock();
    stop_test();
  end
endmodule

`default_nettype wire
